/* hdl/dcie_pkg.sv */
// dcie_pkg: shared constants and types for the dual-channel input evaluator
// assumes: used by dcie_evaluator, dcie_pair_eval, dcie_evaluator_asserts and tb_dcie_evaluator
package dcie_pkg;

  // ****************************************
  // evaluation modes
  // ****************************************
  typedef enum logic [2:0] {
    DCIE_MODE_SINGLE = 3'h0,
    DCIE_MODE_DUAL_EQU = 3'h1,
    DCIE_MODE_DUAL_CMP = 3'h2,
    DCIE_MODE_TWO_EQU = 3'h3,
    DCIE_MODE_TWO_CMP = 3'h4
  } dcie_mode_type;

  // ****************************************
  // output select positions (exposure mask)
  // ****************************************
  localparam int DCIE_OUT_COUNT = 11;
  localparam int DCIE_SEL_OUT_EN = 0;
  localparam int DCIE_SEL_STATIC_REL = 1;
  localparam int DCIE_SEL_DISC_ERR = 2;
  localparam int DCIE_SEL_SYNC_ERR = 3;
  localparam int DCIE_SEL_EXT_CHK_ERR = 4;
  localparam int DCIE_SEL_FAULT = 5;
  localparam int DCIE_SEL_RESET_REQ = 6;
  localparam int DCIE_SEL_RESTART_REQ = 7;
  localparam int DCIE_SEL_SWITCH_A = 8;
  localparam int DCIE_SEL_SWITCH_B = 9;
  localparam int DCIE_SEL_REMOTE_STAT = 10;
  // default exposure: output enable plus the required-action outputs
  localparam logic [10:0] DCIE_SHOW_DEFAULT = 11'h0C1;
  localparam logic [3:0] DCIE_SHOW_COUNT_DEFAULT = 4'h3;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic DCIE_RESULT_RESET = 1'b0;
  localparam logic DCIE_FAULT_RESET = 1'b0;

endpackage : dcie_pkg

/* hdl/dcie_pair_eval.sv */
// dcie_pair_eval: combinational evaluation of one input pair
// assumes: inputs already sampled in the scan clock domain
`timescale 1ns/1ns
`default_nettype none
module dcie_pair_eval
  import dcie_pkg::*;
(
  // pair inputs
  input wire logic in_a_i,
  input wire logic in_b_i,
  // pair config
  input wire logic complementary_i,
  input wire logic same_source_i,
  // results
  output logic active_o,
  output logic discrepant_o
);

  logic b_eff;

  // ****************************************
  // pair truth table
  // ****************************************
  always_comb begin
    b_eff = same_source_i ? (complementary_i ? ~in_a_i : in_a_i) : in_b_i;
    if (complementary_i) begin
      active_o = in_a_i & ~b_eff;
      discrepant_o = ~(in_a_i ^ b_eff);
    end else begin
      active_o = in_a_i & b_eff;
      discrepant_o = in_a_i ^ b_eff;
    end
  end

endmodule : dcie_pair_eval
`default_nettype wire

/* hdl/dcie_evaluator.sv */
// dcie_evaluator: safety input evaluation stage of the logic engine
// assumes: all inputs synchronous to ref_clk_i; scan_tick_i marks scan boundaries;
// discrepancy and sync timing are judged upstream and arrive as error flags
//
// Function
// - dual complementary: result high only for first 1, second 0
// - fault flag set forces result low in every mode
// - two-pair equivalent: enable only when all four inputs are 1, no fault
// - two-pair complementary: enable only for A=1,B=0 on both pairs
// - same source on both inputs of pair 1: use first connection, ignore second
// - single-channel mode lets a pre-evaluated remote bit drive the block
// - remote status separates normal inactive from fault-caused inactive
// - one physical output per result; more need an explicit routing block
// - provide enable, release, error, fault, request and two switching outputs
// - exposure configurable; default shows enable and required-action outputs
// - internal fault raises flag; single mode follows input while fault-free
// - dual equivalent: result high only when both inputs are 1
// - discrepancy: enable low, fault set, pair error bit set
`timescale 1ns/1ns
`default_nettype none
module dcie_evaluator
  import dcie_pkg::*;
#(
  parameter int OUT_COUNT = DCIE_OUT_COUNT
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // scan control
  input wire logic scan_tick_i,
  // configuration
  input wire dcie_mode_type mode_i,
  input wire logic same_source_i,
  input wire logic [OUT_COUNT-1:0] show_mask_i,
  input wire logic [1:0] phys_route_i,
  // safety inputs
  input wire logic in1_a_i,
  input wire logic in1_b_i,
  input wire logic in2_a_i,
  input wire logic in2_b_i,
  // remote status of the single input: 1 = inactive due to device fault
  input wire logic remote_fault_status_i,
  // upstream error causes
  input wire logic internal_fault_i,
  input wire logic disc_timeout1_i,
  input wire logic disc_timeout2_i,
  input wire logic sync_timeout_i,
  input wire logic ext_check_err_i,
  input wire logic fault_clear_i,
  input wire logic reset_req_i,
  input wire logic restart_req_i,
  // results
  output logic out_enable_o,
  output logic static_release_o,
  output logic disc_err1_o,
  output logic disc_err2_o,
  output logic sync_err_o,
  output logic external_device_check_err_o,
  output logic fault_present_o,
  output logic reset_required_o,
  output logic restart_required_o,
  output logic safety_switch_out_a_o,
  output logic safety_switch_out_b_o,
  output logic remote_fault_inactive_o,
  output logic phys_out_o,
  output logic route_needed_o
);

  // the output set is fixed, so no other width can be served
  if (OUT_COUNT != DCIE_OUT_COUNT) begin : g_bad_count
    $error("dcie_evaluator: OUT_COUNT must match the output set");
  end

  logic act1, act2, disc1, disc2;
  logic raw_result;
  logic result_reg, result_next;
  logic fault_reg, fault_next;
  logic disc1_reg, disc1_next;
  logic disc2_reg, disc2_next;
  logic sync_reg, sync_next;
  logic ext_reg, ext_next;
  logic rreq_reg, rreq_next;
  logic rstr_reg, rstr_next;
  logic rstat_reg, rstat_next;
  logic phys_reg, phys_next;
  logic route_reg, route_next;
  logic [OUT_COUNT-1:0] shown_reg, shown_next;
  logic [OUT_COUNT-1:0] out_vec;

  // ****************************************
  // pair evaluation
  // ****************************************
  dcie_pair_eval u_pair1 (
    .in_a_i(in1_a_i),
    .in_b_i(in1_b_i),
    .complementary_i(mode_i == DCIE_MODE_DUAL_CMP || mode_i == DCIE_MODE_TWO_CMP),
    .same_source_i(same_source_i),
    .active_o(act1),
    .discrepant_o(disc1)
  );

  dcie_pair_eval u_pair2 (
    .in_a_i(in2_a_i),
    .in_b_i(in2_b_i),
    .complementary_i(mode_i == DCIE_MODE_TWO_CMP),
    .same_source_i(1'b0),
    .active_o(act2),
    .discrepant_o(disc2)
  );

  // ****************************************
  // mode selection and fault handling
  // ****************************************
  always_comb begin
    unique case (mode_i)
      DCIE_MODE_SINGLE: raw_result = in1_a_i;
      DCIE_MODE_DUAL_EQU: raw_result = act1;
      DCIE_MODE_DUAL_CMP: raw_result = act1;
      DCIE_MODE_TWO_EQU: raw_result = act1 & act2;
      DCIE_MODE_TWO_CMP: raw_result = act1 & act2;
      default: raw_result = 1'b0;
    endcase
  end

  always_comb begin
    disc1_next = disc1_reg;
    disc2_next = disc2_reg;
    sync_next = sync_reg;
    ext_next = ext_reg;
    fault_next = fault_reg;
    result_next = result_reg;
    rreq_next = rreq_reg;
    rstr_next = rstr_reg;
    rstat_next = rstat_reg;
    phys_next = phys_reg;
    route_next = route_reg;
    shown_next = shown_reg;
    if (scan_tick_i) begin
      // clear only when the pair is back inactive; a new cause wins over clear
      if (fault_clear_i && !raw_result) begin
        disc1_next = 1'b0;
        disc2_next = 1'b0;
        sync_next = 1'b0;
        ext_next = 1'b0;
        fault_next = 1'b0;
      end
      if (disc_timeout1_i && mode_i != DCIE_MODE_SINGLE && disc1) begin
        disc1_next = 1'b1;
      end
      if (disc_timeout2_i && (mode_i == DCIE_MODE_TWO_EQU || mode_i == DCIE_MODE_TWO_CMP)
          && disc2) begin
        disc2_next = 1'b1;
      end
      if (sync_timeout_i) begin
        sync_next = 1'b1;
      end
      if (ext_check_err_i) begin
        ext_next = 1'b1;
      end
      if (internal_fault_i || disc1_next || disc2_next || sync_next || ext_next) begin
        fault_next = 1'b1;
      end
      result_next = raw_result & ~fault_next;
      rreq_next = reset_req_i;
      rstr_next = restart_req_i;
      rstat_next = (mode_i == DCIE_MODE_SINGLE) & ~in1_a_i & remote_fault_status_i;
      phys_next = phys_route_i[0] & result_next;
      route_next = phys_route_i[0] & phys_route_i[1];
      shown_next = show_mask_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result_reg <= DCIE_RESULT_RESET;
      fault_reg <= DCIE_FAULT_RESET;
      disc1_reg <= 1'b0;
      disc2_reg <= 1'b0;
      sync_reg <= 1'b0;
      ext_reg <= 1'b0;
      rreq_reg <= 1'b0;
      rstr_reg <= 1'b0;
      rstat_reg <= 1'b0;
      phys_reg <= 1'b0;
      route_reg <= 1'b0;
      shown_reg <= DCIE_SHOW_DEFAULT;
    end else begin
      result_reg <= result_next;
      fault_reg <= fault_next;
      disc1_reg <= disc1_next;
      disc2_reg <= disc2_next;
      sync_reg <= sync_next;
      ext_reg <= ext_next;
      rreq_reg <= rreq_next;
      rstr_reg <= rstr_next;
      rstat_reg <= rstat_next;
      phys_reg <= phys_next;
      route_reg <= route_next;
      shown_reg <= shown_next;
    end
  end

  // ****************************************
  // output exposure gating
  // ****************************************
  // full output set
  always_comb begin
    out_vec = '0;
    out_vec[DCIE_SEL_OUT_EN] = result_next;
    out_vec[DCIE_SEL_STATIC_REL] = result_next;
    out_vec[DCIE_SEL_DISC_ERR] = disc1_next | disc2_next;
    out_vec[DCIE_SEL_SYNC_ERR] = sync_next;
    out_vec[DCIE_SEL_EXT_CHK_ERR] = ext_next;
    out_vec[DCIE_SEL_FAULT] = fault_next;
    out_vec[DCIE_SEL_RESET_REQ] = rreq_next;
    out_vec[DCIE_SEL_RESTART_REQ] = rstr_next;
    out_vec[DCIE_SEL_SWITCH_A] = result_next;
    out_vec[DCIE_SEL_SWITCH_B] = result_next;
    out_vec[DCIE_SEL_REMOTE_STAT] = rstat_next;
  end

  // mask applied ahead of the flops so that every output leaves a register
  logic [OUT_COUNT-1:0] gated_next, gated_reg;
  logic err1_next, err1_reg, err2_next, err2_reg;
  always_comb begin
    gated_next = out_vec & shown_next;
    err1_next = gated_next[DCIE_SEL_DISC_ERR] & disc1_next;
    err2_next = gated_next[DCIE_SEL_DISC_ERR] & disc2_next;
  end

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gated_reg <= '0;
      err1_reg <= 1'b0;
      err2_reg <= 1'b0;
    end else begin
      gated_reg <= gated_next;
      err1_reg <= err1_next;
      err2_reg <= err2_next;
    end
  end

  assign out_enable_o = gated_reg[DCIE_SEL_OUT_EN];
  assign static_release_o = gated_reg[DCIE_SEL_STATIC_REL];
  assign disc_err1_o = err1_reg;
  assign disc_err2_o = err2_reg;
  assign sync_err_o = gated_reg[DCIE_SEL_SYNC_ERR];
  assign external_device_check_err_o = gated_reg[DCIE_SEL_EXT_CHK_ERR];
  assign fault_present_o = gated_reg[DCIE_SEL_FAULT];
  assign reset_required_o = gated_reg[DCIE_SEL_RESET_REQ];
  assign restart_required_o = gated_reg[DCIE_SEL_RESTART_REQ];
  assign safety_switch_out_a_o = gated_reg[DCIE_SEL_SWITCH_A];
  assign safety_switch_out_b_o = gated_reg[DCIE_SEL_SWITCH_B];
  assign remote_fault_inactive_o = gated_reg[DCIE_SEL_REMOTE_STAT];
  assign phys_out_o = phys_reg;
  assign route_needed_o = route_reg;

endmodule : dcie_evaluator
`default_nettype wire

/* verif/dcie_input_dev.sv */
// dcie_input_dev: local or remote safety input devices at the evaluator inputs
// assumes: the bench sets the contact pattern off the clock edge
`timescale 1ns/1ns
`default_nettype none
module dcie_input_dev (
  // stimulus
  input wire logic [3:0] pat_i,
  input wire logic dev_fault_i,
  // device side
  output logic in1_a_o,
  output logic in1_b_o,
  output logic in2_a_o,
  output logic in2_b_o,
  output logic status_o
);
  assign {in1_a_o, in1_b_o, in2_a_o, in2_b_o} = pat_i;
  assign status_o = dev_fault_i;
endmodule : dcie_input_dev
`default_nettype wire

/* verif/dcie_evaluator_asserts.sv */
// dcie_evaluator_asserts: port-level checks of the evaluator
// assumes: bound into dcie_evaluator, one clock domain
`timescale 1ns/1ns
`default_nettype none
module dcie_evaluator_asserts
  import dcie_pkg::*;
#(
  parameter int OUT_COUNT = DCIE_OUT_COUNT
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // inputs
  input wire logic scan_tick_i,
  input wire dcie_mode_type mode_i,
  input wire logic same_source_i,
  input wire logic [1:0] phys_route_i,
  input wire logic in1_a_i,
  input wire logic in1_b_i,
  input wire logic in2_a_i,
  input wire logic in2_b_i,
  input wire logic internal_fault_i,
  // outputs
  input wire logic out_enable_o,
  input wire logic disc_err1_o,
  input wire logic phys_out_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // shared source rewires pair 1, so the truth checks skip it
  logic pt;
  assign pt = scan_tick_i && !same_source_i;
  scan_hold_a: assert property (!$past(scan_tick_i) |-> $stable(out_enable_o))
    else $error("enable moved between scan ticks");
  fault_force_a: assert property (scan_tick_i && internal_fault_i |=> !out_enable_o)
    else $error("enable high under fault");
  dual_cmp_a: assert property (
    pt && mode_i == DCIE_MODE_DUAL_CMP && !(in1_a_i && !in1_b_i) |=> !out_enable_o)
    else $error("dual complementary enable wrong");
  dual_equ_a: assert property (
    pt && mode_i == DCIE_MODE_DUAL_EQU && !(in1_a_i && in1_b_i) |=> !out_enable_o)
    else $error("dual equivalent enable wrong");
  two_equ_a: assert property (
    pt && mode_i == DCIE_MODE_TWO_EQU && !(in1_a_i && in1_b_i && in2_a_i && in2_b_i)
    |=> !out_enable_o) else $error("two pair equivalent enable wrong");
  two_cmp_a: assert property (
    pt && mode_i == DCIE_MODE_TWO_CMP && {in1_a_i, in1_b_i, in2_a_i, in2_b_i} != 4'hA
    |=> !out_enable_o) else $error("two pair complementary enable wrong");
  disc_block_a: assert property (disc_err1_o |-> !out_enable_o)
    else $error("enable high with discrepancy error");
  phys_gate_a: assert property (scan_tick_i && !phys_route_i[0] |=> !phys_out_o)
    else $error("physical output driven without route");
endmodule : dcie_evaluator_asserts
bind dcie_evaluator dcie_evaluator_asserts #(.OUT_COUNT(OUT_COUNT)) i_chk (
  .ref_clk_i, .reset_n_i, .scan_tick_i, .mode_i, .same_source_i, .phys_route_i,
  .in1_a_i, .in1_b_i, .in2_a_i, .in2_b_i, .internal_fault_i, .out_enable_o,
  .disc_err1_o, .phys_out_o);
`default_nettype wire

/* verif/tb_dcie_evaluator.sv */
// tb_dcie_evaluator: scenario bench for the input evaluator
// assumes: one 10 MHz scan clock; inputs move on its falling edge
`timescale 1ns/1ns
`default_nettype none
module tb_dcie_evaluator
  import dcie_pkg::*;
;
  logic ref_clk_i, reset_n_i, scan_tick_i, same_source_i, internal_fault_i, rstat;
  logic disc_timeout1_i, disc_timeout2_i, sync_timeout_i, ext_check_err_i;
  logic fault_clear_i, reset_req_i, restart_req_i, remote_fault_status_i;
  logic in1_a_i, in1_b_i, in2_a_i, in2_b_i, out_enable_o, disc_err1_o, disc_err2_o;
  logic sync_err_o, external_device_check_err_o, fault_present_o, reset_required_o;
  logic restart_required_o, remote_fault_inactive_o, phys_out_o, route_needed_o;
  logic static_release_o, safety_switch_out_a_o, safety_switch_out_b_o;
  dcie_mode_type mode_i;
  logic [10:0] show_mask_i;
  logic [1:0] phys_route_i;
  logic [3:0] pat;
  int errors = 0;
  int checks = 0;
  dcie_input_dev i_dev (.pat_i(pat), .dev_fault_i(rstat), .in1_a_o(in1_a_i), .in1_b_o(in1_b_i),
    .in2_a_o(in2_a_i), .in2_b_o(in2_b_i), .status_o(remote_fault_status_i));
  dcie_evaluator i_dut (.ref_clk_i, .reset_n_i, .scan_tick_i, .mode_i, .same_source_i,
    .show_mask_i, .phys_route_i, .in1_a_i, .in1_b_i, .in2_a_i, .in2_b_i,
    .remote_fault_status_i, .internal_fault_i, .disc_timeout1_i, .disc_timeout2_i,
    .sync_timeout_i, .ext_check_err_i, .fault_clear_i, .reset_req_i, .restart_req_i,
    .out_enable_o, .static_release_o, .disc_err1_o, .disc_err2_o, .sync_err_o,
    .external_device_check_err_o, .fault_present_o, .reset_required_o,
    .restart_required_o, .safety_switch_out_a_o, .safety_switch_out_b_o,
    .remote_fault_inactive_o, .phys_out_o, .route_needed_o);
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input string n, input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %b seen %b", n, exp, seen);
    end
  endtask : chk
  function automatic logic want(input int m, input logic [3:0] p);
    return m == 0 ? p[3] : m == 1 ? p[3] & p[2] : m == 2 ? p[3] & ~p[2] : m == 3 ? &p : p == 4'hA;
  endfunction : want
  // tick stays high so scans may run back to back
  task automatic scan(input dcie_mode_type m, input logic [3:0] p);
    mode_i = m;
    pat = p;
    scan_tick_i = 1'b1;
    @(negedge ref_clk_i);
  endtask : scan
  task automatic t_modes();
    for (int m = 0; m < 5; m++) begin
      for (int p = 0; p < 16; p++) begin
        scan(dcie_mode_type'(m), p[3:0]);
        chk("out_enable_o", out_enable_o, want(m, p[3:0]));
      end
    end
  endtask : t_modes
  task automatic t_hold();
    same_source_i = 1'b1;
    scan(DCIE_MODE_DUAL_EQU, 4'h8);
    chk("same_src", out_enable_o, 1'b1);
    scan_tick_i = 1'b0;
    pat = 4'h0;
    repeat (3) @(negedge ref_clk_i);
    chk("hold", out_enable_o, 1'b1);
    same_source_i = 1'b0;
  endtask : t_hold
  task automatic t_route();
    phys_route_i = 2'h1;
    scan(DCIE_MODE_SINGLE, 4'h8);
    chk("phys_out_o", phys_out_o, 1'b1);
    chk("route_one", route_needed_o, 1'b0);
    phys_route_i = 2'h3;
    scan(DCIE_MODE_SINGLE, 4'h8);
    chk("route_two", route_needed_o, 1'b1);
  endtask : t_route
  task automatic t_disc();
    {disc_timeout1_i, disc_timeout2_i} = 2'h3;
    scan(DCIE_MODE_DUAL_EQU, 4'h8);
    chk("disc_en", out_enable_o, 1'b0);
    chk("disc_fault", fault_present_o, 1'b1);
    chk("disc_1", disc_err1_o, 1'b1);
    chk("disc_2", disc_err2_o, 1'b0);
    {disc_timeout1_i, disc_timeout2_i, fault_clear_i} = 3'h1;
    scan(DCIE_MODE_DUAL_EQU, 4'h0);
    chk("disc_clear", disc_err1_o, 1'b0);
  endtask : t_disc
  task automatic t_fault();
    show_mask_i = DCIE_SHOW_DEFAULT;
    {internal_fault_i, fault_clear_i, reset_req_i} = 3'h5;
    scan(DCIE_MODE_TWO_CMP, 4'hA);
    chk("fault_en", out_enable_o, 1'b0);
    chk("fault_hidden", fault_present_o, 1'b0);
    chk("reset_req", reset_required_o, 1'b1);
    show_mask_i = 11'h7FF;
    {internal_fault_i, fault_clear_i} = 2'h1;
    scan(DCIE_MODE_TWO_CMP, 4'hA);
    chk("clear_refused", fault_present_o, 1'b1);
    scan(DCIE_MODE_TWO_CMP, 4'h0);
    chk("clear_done", fault_present_o, 1'b0);
    fault_clear_i = 1'b0;
    scan(DCIE_MODE_TWO_CMP, 4'hA);
    chk("enable_back", out_enable_o, 1'b1);
    chk("static_rel", static_release_o, 1'b1);
    chk("switch_a", safety_switch_out_a_o, 1'b1);
    chk("switch_b", safety_switch_out_b_o, 1'b1);
  endtask : t_fault
  task automatic t_pass();
    rstat = 1'b1;
    scan(DCIE_MODE_SINGLE, 4'h0);
    chk("remote_fault", remote_fault_inactive_o, 1'b1);
    {sync_timeout_i, ext_check_err_i, restart_req_i} = 3'h7;
    scan(DCIE_MODE_SINGLE, 4'h0);
    chk("sync_err_o", sync_err_o, 1'b1);
    chk("ext_check", external_device_check_err_o, 1'b1);
    chk("restart_req", restart_required_o, 1'b1);
  endtask : t_pass
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // about 90 scans are needed; this leaves ample margin
  initial begin
    #200000;
    errors++;
    wrap_up();
  end
  initial begin
    {reset_n_i, scan_tick_i, same_source_i, internal_fault_i, disc_timeout1_i,
      disc_timeout2_i, sync_timeout_i, ext_check_err_i, fault_clear_i, reset_req_i,
      restart_req_i, rstat} = 12'h000;
    mode_i = DCIE_MODE_SINGLE;
    show_mask_i = 11'h7FF;
    phys_route_i = 2'h0;
    pat = 4'h0;
    repeat (2) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    t_modes();
    t_hold();
    t_route();
    t_disc();
    t_fault();
    t_pass();
    wrap_up();
  end
endmodule : tb_dcie_evaluator
`default_nettype wire
